// >>> shared/chg_regs.svh
`ifndef CHG_REGS_SVH
`define CHG_REGS_SVH

// ----------------------------------------
// Timing figures
// ----------------------------------------
`define CHG_CLK_MHZ 100
`define CHG_ALERT_PULSE_US 256
`define CHG_RESET_HOLD_S 8
`define CHG_SWITCH_OFF_MS 250
`define CHG_SHIP_EXIT_MS 10
`define CHG_BLINK_HZ 1
`define CHG_BC_STEP_US 100
`define CHG_DCD_TMO_MS 300

// ----------------------------------------
// Register indices
// ----------------------------------------
`define CHG_IDX_CTRL 8'h00
`define CHG_IDX_ILIM 8'h01
`define CHG_IDX_STATUS 8'h02
`define CHG_IDX_IRQ_STAT 8'h03
`define CHG_IDX_IRQ_CLR 8'h04
`define CHG_IDX_IRQ_EN 8'h05

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define CHG_CTRL_HOST 0
`define CHG_CTRL_SHIP 1
`define CHG_ILIM_LOW 5'h05
`define CHG_ILIM_HIGH 5'h18
`define CHG_ILIM_RST 5'h05
`define CHG_IRQ_CHG 0
`define CHG_IRQ_FLT 1
`define CHG_IRQ_SHIP 2
`define CHG_IRQ_RST 3
`define CHG_IRQ_EN_RST 4'h0
`define CHG_I2C_ADDR 7'h6B

`endif

// >>> shared/chg_pkg.sv
`default_nettype none
package chg_pkg;
  typedef enum logic [1:0] {SW_ON, SW_SHIP, SW_RST_OFF} chg_sw_t;
  typedef enum logic [2:0] {BC_IDLE, BC_DCD, BC_PRI, BC_SEC, BC_DONE}
    chg_bc_t;
  typedef enum logic [2:0] {I2_IDLE, I2_ADDR, I2_AACK, I2_WR, I2_WACK,
    I2_RD, I2_RACK} chg_i2_t;
  typedef enum logic [1:0] {PORT_NONE, PORT_SDP, PORT_CDP, PORT_DCP}
    chg_port_t;

  // Serial target write
  typedef struct packed {
    logic en;
    logic [7:0] idx;
    logic [7:0] data;
  } chg_wr_t;

  // Pin inputs, raw and synchronised
  typedef struct packed {
    logic ce_n;
    logic psel;
    logic qon_n;
    logic ts_ok;
    logic src_good;
    logic fault;
    logic done;
    logic dcd;
    logic pri;
    logic sec;
    logic scl;
    logic sda;
  } chg_pins_t;

  typedef struct packed {
    chg_i2_t st;
    logic [3:0] bcnt;
    logic [7:0] sh;
    logic first;
    logic nack;
    logic [7:0] ptr;
    logic scl_p;
    logic sda_p;
    logic sda_oe;
    chg_wr_t wr;
  } chg_i2c_st_t;

  typedef struct packed {
    logic av_wait;
    logic [31:0] av_rdata;
    logic [7:0] i2c_rdata;
    logic host_mode;
    logic ilim_set;
    logic [4:0] ilim_reg;
    logic [3:0] irq_stat;
    logic [3:0] irq_en;
    logic [7:0] stat_prev;
    logic fault_prev;
    logic [31:0] alert_cnt;
    logic alert_oe;
    logic [31:0] blink_cnt;
    logic blink_oe;
    logic [31:0] qon_cnt;
    chg_sw_t sw;
    logic [31:0] sw_cnt;
    chg_bc_t bc;
    logic [31:0] bc_cnt;
    chg_port_t port;
    logic charge_on;
    logic stat_oe;
    logic pg_oe;
    logic irq;
    logic [4:0] ilim;
  } chg_st_t;
endpackage
`default_nettype wire

// >>> core/chg_sync.sv
`default_nettype none
module chg_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;

  // Two-stage synchroniser, idle level at reset
  always_ff @(posedge clock) begin
    if (reset) begin
      meta_ff <= INIT;
      q <= INIT;
    end else begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end
endmodule // chg_sync
`default_nettype wire

// >>> core/chg_i2c_tgt.sv
`default_nettype none
`include "chg_regs.svh"
module chg_i2c_tgt #(
  parameter logic [6:0] ADDR = `CHG_I2C_ADDR
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic scl_s,
  input wire logic sda_s,
  input wire logic [7:0] rdata,
  output logic [7:0] ptr,
  output chg_pkg::chg_wr_t wr,
  output logic sda_oe
);
  chg_pkg::chg_i2c_st_t q, n;
  logic rise, fall, start, stop;

  // ----------------------------------------
  // Bus conditions
  // ----------------------------------------
  assign rise = scl_s && !q.scl_p;
  assign fall = !scl_s && q.scl_p;
  assign start = scl_s && q.scl_p && q.sda_p && !sda_s;
  assign stop = scl_s && q.scl_p && !q.sda_p && sda_s;

  // Byte engine: pointer byte first, then data
  always_comb begin
    n = q;
    n.scl_p = scl_s;
    n.sda_p = sda_s;
    n.wr.en = 1'b0;
    if (start) begin
      n.st = chg_pkg::I2_ADDR;
      n.bcnt = 4'h0;
      n.first = 1'b1;
      n.sda_oe = 1'b0;
    end else if (stop) begin
      n.st = chg_pkg::I2_IDLE;
      n.sda_oe = 1'b0;
    end else begin
      unique case (q.st)
        chg_pkg::I2_IDLE: ;
        chg_pkg::I2_ADDR, chg_pkg::I2_WR: begin
          if (rise) begin
            n.sh = {q.sh[6:0], sda_s};
            n.bcnt = q.bcnt + 4'h1;
          end else if (fall && q.bcnt == 4'h8) begin
            n.sda_oe = 1'b1;
            if (q.st == chg_pkg::I2_ADDR) begin
              n.st = (q.sh[7:1] == ADDR) ? chg_pkg::I2_AACK
                                         : chg_pkg::I2_IDLE;
              n.sda_oe = (q.sh[7:1] == ADDR);
            end else begin
              n.st = chg_pkg::I2_WACK;
              n.first = 1'b0;
              if (q.first) begin
                n.ptr = q.sh;
              end else begin
                n.wr.en = 1'b1;
                n.wr.idx = q.ptr;
                n.wr.data = q.sh;
                n.ptr = q.ptr + 8'h01;
              end
            end
          end
        end
        chg_pkg::I2_AACK: begin
          if (fall) begin
            n.bcnt = 4'h0;
            if (q.sh[0]) begin
              n.st = chg_pkg::I2_RD;
              n.sh = rdata;
              n.sda_oe = !rdata[7];
            end else begin
              n.st = chg_pkg::I2_WR;
              n.sda_oe = 1'b0;
            end
          end
        end
        chg_pkg::I2_WACK: begin
          if (fall) begin
            n.st = chg_pkg::I2_WR;
            n.bcnt = 4'h0;
            n.sda_oe = 1'b0;
          end
        end
        chg_pkg::I2_RD: begin
          if (rise) begin
            n.bcnt = q.bcnt + 4'h1;
          end else if (fall) begin
            if (q.bcnt == 4'h8) begin
              n.st = chg_pkg::I2_RACK;
              n.sda_oe = 1'b0;
            end else begin
              n.sh = {q.sh[6:0], 1'b0};
              n.sda_oe = !q.sh[6];
            end
          end
        end
        chg_pkg::I2_RACK: begin
          if (rise) begin
            n.nack = sda_s;
            n.ptr = q.ptr + 8'h01;
          end else if (fall) begin
            n.bcnt = 4'h0;
            n.st = q.nack ? chg_pkg::I2_IDLE : chg_pkg::I2_RD;
            n.sh = rdata;
            n.sda_oe = !q.nack && !rdata[7];
          end
        end
        default: n.st = chg_pkg::I2_IDLE;
      endcase
    end
  end

  // State register
  always_ff @(posedge clock) begin
    if (reset) begin
      q <= '0;
      q.scl_p <= 1'b1;
      q.sda_p <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign ptr = q.ptr;
  assign wr = q.wr;
  assign sda_oe = q.sda_oe;
endmodule // chg_i2c_tgt
`default_nettype wire

// >>> core/chg_pins.sv
// Contract
// - Charge only while charge enable low
// - Alert pulse low for 256 us
// - Source select picks 500 mA / 2.4 A; with HAS_USB_DATA set the detected port picks instead
// - Host-written limit replaces default in host mode
// - Held low ends ship mode
// - 8 s low, no source: switch off 250 ms
// - Undriven wake input reads high
// - Status pin: low, high, or 1 Hz blink
// - Thermistor out of window suspends charge
// - Port detection: contact, primary, secondary
// - Supply good low with good source; never driven when HAS_USB_DATA is set
// - Serial target: clock in, data open-drain
// - Alert on fault without host access
//
// Local design decisions: the Avalon-MM register port and the register addresses.
`default_nettype none
`include "chg_regs.svh"
module chg_pins #(
  parameter bit HAS_USB_DATA = 1'b0,
  parameter int unsigned ALERT_CYC = `CHG_ALERT_PULSE_US * `CHG_CLK_MHZ,
  parameter int unsigned RESET_HOLD_CYC =
    `CHG_RESET_HOLD_S * `CHG_CLK_MHZ * 1000000,
  parameter int unsigned SWITCH_OFF_CYC =
    `CHG_SWITCH_OFF_MS * `CHG_CLK_MHZ * 1000,
  parameter int unsigned SHIP_EXIT_CYC =
    `CHG_SHIP_EXIT_MS * `CHG_CLK_MHZ * 1000,
  parameter int unsigned BLINK_HALF_CYC =
    `CHG_CLK_MHZ * 1000000 / (2 * `CHG_BLINK_HZ),
  parameter int unsigned BC_STEP_CYC = `CHG_BC_STEP_US * `CHG_CLK_MHZ,
  parameter int unsigned DCD_TMO_CYC = `CHG_DCD_TMO_MS * `CHG_CLK_MHZ * 1000
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic charge_enable_n,
  input wire logic source_select_in,
  input wire logic ship_wake_reset_n,
  input wire logic ship_wake_driven,
  input wire logic thermistor_window_ok,
  input wire logic source_good_in,
  input wire logic fault_in,
  input wire logic charge_done_in,
  input wire logic dcd_contact_in,
  input wire logic primary_det_in,
  input wire logic secondary_det_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic host_alert_oe,
  output logic charge_state_oe,
  output logic supply_good_oe,
  output logic battery_switch_on,
  output logic charge_on,
  output logic [4:0] input_current_limit_setting,
  output logic irq
);
  chg_pkg::chg_st_t q, n;
  chg_pkg::chg_pins_t raw, pin;
  chg_pkg::chg_wr_t i2c_wr;
  logic [7:0] i2c_ptr;
  logic i2c_sda_oe;

  // ----------------------------------------
  // Pin synchronisation and serial target
  // ----------------------------------------
  // pull-up default
  assign raw = '{ce_n: charge_enable_n, psel: source_select_in,
    qon_n: ship_wake_driven ? ship_wake_reset_n : 1'b1,
    ts_ok: thermistor_window_ok, src_good: source_good_in,
    fault: fault_in, done: charge_done_in, dcd: dcd_contact_in,
    pri: primary_det_in, sec: secondary_det_in, scl: scl_in,
    sda: sda_in};

  chg_sync #(
    .W($bits(chg_pkg::chg_pins_t)),
    .INIT(12'hF03)
  ) u_sync (
    .clock(clock),
    .reset(reset),
    .d(raw),
    .q(pin)
  );

  chg_i2c_tgt u_i2c (
    .clock(clock),
    .reset(reset),
    .scl_s(pin.scl),
    .sda_s(pin.sda),
    .rdata(q.i2c_rdata),
    .ptr(i2c_ptr),
    .wr(i2c_wr),
    .sda_oe(i2c_sda_oe)
  );

  // Register read mux
  function automatic logic [7:0] rd(input logic [7:0] idx,
                                    input chg_pkg::chg_st_t s,
                                    input logic [7:0] sts);
    logic [7:0] v;
    unique case (idx)
      `CHG_IDX_CTRL: v = {7'h00, s.host_mode};
      `CHG_IDX_ILIM: v = {3'h0, s.ilim_reg};
      `CHG_IDX_STATUS: v = sts;
      `CHG_IDX_IRQ_STAT: v = {4'h0, s.irq_stat};
      `CHG_IDX_IRQ_EN: v = {4'h0, s.irq_en};
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    logic fault, pg, wr_en, av_go;
    logic [7:0] sts, wr_idx, wr_data;
    logic [3:0] ev, clr;
    logic [4:0] dflt;
    fault = 1'b0;
    pg = 1'b0;
    wr_en = 1'b0;
    av_go = 1'b0;
    sts = 8'h00;
    wr_idx = 8'h00;
    wr_data = 8'h00;
    ev = 4'h0;
    clr = 4'h0;
    dflt = `CHG_ILIM_LOW;
    n = q;

    fault = !pin.ts_ok || pin.fault;
    pg = pin.src_good;
    n.charge_on = !pin.ce_n && pg && !fault && !pin.done &&
                  (q.sw == chg_pkg::SW_ON);
    sts = {q.bc == chg_pkg::BC_DONE, q.port, q.sw == chg_pkg::SW_SHIP,
           pg, fault, pin.done, q.charge_on};

    // Bus slave: one wait cycle
    av_go = (avs_read || avs_write) && !q.av_wait;
    n.av_wait = !((avs_read || avs_write) && q.av_wait);
    if ((avs_read || avs_write) && q.av_wait) begin
      n.av_rdata = {24'h000000, rd({2'b00, avs_address[7:2]}, q, sts)};
    end
    n.i2c_rdata = rd(i2c_ptr, q, sts);
    if (av_go && avs_write && avs_byteenable[0]) begin
      wr_en = 1'b1;
      wr_idx = {2'b00, avs_address[7:2]};
      wr_data = avs_writedata[7:0];
    end else if (i2c_wr.en) begin
      wr_en = 1'b1;
      wr_idx = i2c_wr.idx;
      wr_data = i2c_wr.data;
    end

    // Register writes
    if (wr_en) begin
      unique case (wr_idx)
        `CHG_IDX_CTRL: begin
          n.host_mode = wr_data[`CHG_CTRL_HOST];
          if (!wr_data[`CHG_CTRL_HOST]) begin
            n.ilim_set = 1'b0;
          end
          if (wr_data[`CHG_CTRL_SHIP] && q.sw == chg_pkg::SW_ON) begin
            n.sw = chg_pkg::SW_SHIP;
          end
        end
        `CHG_IDX_ILIM: begin
          if (q.host_mode) begin
            n.ilim_reg = wr_data[4:0];
            n.ilim_set = 1'b1;
          end
        end
        `CHG_IDX_IRQ_CLR: clr = wr_data[3:0];
        `CHG_IDX_IRQ_EN: n.irq_en = wr_data[3:0];
        default: ;
      endcase
    end

    if (pin.qon_n) begin
      n.qon_cnt = 32'h0;
    end else if (q.qon_cnt != 32'hFFFFFFFF) begin
      n.qon_cnt = q.qon_cnt + 32'h1;
    end

    // Battery switch control
    unique case (q.sw)
      chg_pkg::SW_ON: begin
        if (!pg && n.qon_cnt == RESET_HOLD_CYC) begin
          n.sw = chg_pkg::SW_RST_OFF;
          n.sw_cnt = 32'h0;
        end
      end
      chg_pkg::SW_SHIP: begin
        if (n.qon_cnt == SHIP_EXIT_CYC) begin
          n.sw = chg_pkg::SW_ON;
          ev[`CHG_IRQ_SHIP] = 1'b1;
        end
      end
      chg_pkg::SW_RST_OFF: begin
        n.sw_cnt = q.sw_cnt + 32'h1;
        if (q.sw_cnt == SWITCH_OFF_CYC - 1) begin
          n.sw = chg_pkg::SW_ON;
          ev[`CHG_IRQ_RST] = 1'b1;
        end
      end
      default: n.sw = chg_pkg::SW_ON;
    endcase

    n.bc_cnt = q.bc_cnt + 32'h1;
    if (!HAS_USB_DATA || !pg) begin
      n.bc = chg_pkg::BC_IDLE;
      n.port = chg_pkg::PORT_NONE;
    end else begin
      unique case (q.bc)
        chg_pkg::BC_IDLE: begin
          n.bc = chg_pkg::BC_DCD;
          n.bc_cnt = 32'h0;
        end
        chg_pkg::BC_DCD: begin
          if (pin.dcd || q.bc_cnt == DCD_TMO_CYC - 1) begin
            n.bc = chg_pkg::BC_PRI;
            n.bc_cnt = 32'h0;
          end
        end
        chg_pkg::BC_PRI: begin
          if (q.bc_cnt == BC_STEP_CYC - 1) begin
            n.bc = pin.pri ? chg_pkg::BC_SEC : chg_pkg::BC_DONE;
            n.port = pin.pri ? chg_pkg::PORT_NONE : chg_pkg::PORT_SDP;
            n.bc_cnt = 32'h0;
          end
        end
        chg_pkg::BC_SEC: begin
          if (q.bc_cnt == BC_STEP_CYC - 1) begin
            n.bc = chg_pkg::BC_DONE;
            n.port = pin.sec ? chg_pkg::PORT_DCP : chg_pkg::PORT_CDP;
          end
        end
        chg_pkg::BC_DONE: n.bc_cnt = q.bc_cnt;
        default: n.bc = chg_pkg::BC_IDLE;
      endcase
    end

    if (HAS_USB_DATA) begin
      dflt = (q.port == chg_pkg::PORT_CDP || q.port == chg_pkg::PORT_DCP)
             ? `CHG_ILIM_HIGH : `CHG_ILIM_LOW;
    end else begin
      dflt = pin.psel ? `CHG_ILIM_LOW : `CHG_ILIM_HIGH;
    end
    n.ilim = (q.host_mode && q.ilim_set) ? q.ilim_reg : dflt;

    // Events: status change and fault onset
    n.stat_prev = sts;
    n.fault_prev = fault;
    ev[`CHG_IRQ_CHG] = (sts != q.stat_prev);
    ev[`CHG_IRQ_FLT] = fault && !q.fault_prev;
    // Sticky status, set beats clear
    n.irq_stat = (q.irq_stat & ~clr) | ev;
    n.irq = |(n.irq_stat & n.irq_en);

    if (ev[`CHG_IRQ_CHG] || ev[`CHG_IRQ_FLT]) begin
      n.alert_oe = 1'b1;
      n.alert_cnt = 32'h0;
    end else if (q.alert_oe) begin
      n.alert_cnt = q.alert_cnt + 32'h1;
      if (q.alert_cnt == ALERT_CYC - 1) begin
        n.alert_oe = 1'b0;
      end
    end

    if (!fault) begin
      n.blink_cnt = 32'h0;
      n.blink_oe = 1'b1;
    end else if (q.blink_cnt == BLINK_HALF_CYC - 1) begin
      n.blink_cnt = 32'h0;
      n.blink_oe = !q.blink_oe;
    end else begin
      n.blink_cnt = q.blink_cnt + 32'h1;
    end
    n.stat_oe = fault ? n.blink_oe : n.charge_on;
    // supply good on variant without data lines
    n.pg_oe = !HAS_USB_DATA && pg;
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      q <= '0;
      q.av_wait <= 1'b1;
      q.ilim_reg <= `CHG_ILIM_RST;
      q.ilim <= `CHG_ILIM_RST;
      q.irq_en <= `CHG_IRQ_EN_RST;
      q.blink_oe <= 1'b1;
    end else begin
      q <= n;
    end
  end

  // Outputs straight from state
  assign avs_readdata = q.av_rdata;
  assign avs_waitrequest = q.av_wait;
  assign sda_out = 1'b0;
  assign sda_oe = i2c_sda_oe;
  assign host_alert_oe = q.alert_oe;
  assign charge_state_oe = q.stat_oe;
  assign supply_good_oe = q.pg_oe;
  assign battery_switch_on = (q.sw == chg_pkg::SW_ON);
  assign charge_on = q.charge_on;
  assign input_current_limit_setting = q.ilim;
  assign irq = q.irq;
endmodule // chg_pins
`default_nettype wire

// >>> tb/chg_pins_sva.sv
`default_nettype none
module chg_pins_sva #(
  parameter int unsigned ALERT_CYC = 20,
  parameter int unsigned RESET_HOLD_CYC = 200,
  parameter int unsigned SHIP_EXIT_CYC = 30,
  parameter int unsigned BLINK_HALF_CYC = 16
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic charge_enable_n,
  input wire logic ship_wake_reset_n,
  input wire logic ship_wake_driven,
  input wire logic thermistor_window_ok,
  input wire logic source_good_in,
  input wire logic fault_in,
  input wire logic charge_done_in,
  input wire logic host_alert_oe,
  input wire logic charge_state_oe,
  input wire logic battery_switch_on,
  input wire logic charge_on
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  logic [31:0] alert_ff, stat_ff, flt_ff, low_ff;
  logic prev_ff;
  // Run lengths
  always_ff @(posedge clock) begin
    if (reset) begin
      alert_ff <= 32'h0;
      stat_ff <= 32'h0;
      flt_ff <= 32'h0;
      low_ff <= 32'h0;
      prev_ff <= 1'b0;
    end else begin
      alert_ff <= host_alert_oe ? alert_ff + 32'h1 : 32'h0;
      stat_ff <= (charge_state_oe != prev_ff) ? 32'h1 : stat_ff + 32'h1;
      prev_ff <= charge_state_oe;
      flt_ff <= (!thermistor_window_ok || fault_in) ? flt_ff + 32'h1 : 32'h0;
      low_ff <= (ship_wake_driven && !ship_wake_reset_n) ?
        low_ff + 32'h1 : 32'h0;
    end
  end
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_alert_len;
    $fell(host_alert_oe) |-> alert_ff >= ALERT_CYC;
  endproperty
  a_alert_len: assert property (p_alert_len)
    else $error("alert pulse too short");
  property p_alert_flt;
    $fell(thermistor_window_ok) |-> ##[1:5] host_alert_oe;
  endproperty
  a_alert_flt: assert property (p_alert_flt)
    else $error("no alert after fault");
  property p_no_chg;
    (charge_enable_n || !thermistor_window_ok) [*4] |-> !charge_on;
  endproperty
  a_no_chg: assert property (p_no_chg)
    else $error("charging while disabled");
  property p_stat_chg;
    charge_on [*3] |-> charge_state_oe;
  endproperty
  a_stat_chg: assert property (p_stat_chg)
    else $error("status idle while charging");
  property p_stat_done;
    (charge_done_in && thermistor_window_ok && !fault_in) [*5]
      |-> !charge_state_oe;
  endproperty
  a_stat_done: assert property (p_stat_done)
    else $error("status driven when done");
  property p_blink;
    (flt_ff > 2 * BLINK_HALF_CYC) && $changed(charge_state_oe)
      |-> stat_ff == BLINK_HALF_CYC;
  endproperty
  a_blink: assert property (p_blink)
    else $error("blink half period wrong");
  property p_ship_rise;
    $rose(battery_switch_on) && low_ff < RESET_HOLD_CYC
      |-> low_ff >= SHIP_EXIT_CYC;
  endproperty
  a_ship_rise: assert property (p_ship_rise)
    else $error("switch on too early");
  property p_rst_off;
    (low_ff == RESET_HOLD_CYC + 8) && !source_good_in |-> !battery_switch_on;
  endproperty
  a_rst_off: assert property (p_rst_off)
    else $error("switch still on");
  property p_av_ans;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_av_ans: assert property (p_av_ans)
    else $error("bus answer late");
endmodule // chg_pins_sva

bind chg_pins chg_pins_sva #(.ALERT_CYC(ALERT_CYC),
  .RESET_HOLD_CYC(RESET_HOLD_CYC), .SHIP_EXIT_CYC(SHIP_EXIT_CYC),
  .BLINK_HALF_CYC(BLINK_HALF_CYC)) chk_u (.*);
`default_nettype wire

// >>> tb/chg_host_model.sv
`default_nettype none
`include "chg_regs.svh"
module chg_host_model (
  input wire logic clock,
  input wire logic sda_line,
  input wire logic alert_n,
  output logic scl,
  output logic sda_low,
  output logic [31:0] alert_width,
  output logic [31:0] alert_count
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] run;
  initial begin
    {scl, sda_low, run, alert_width, alert_count} = {2'b10, 96'h0};
  end
  // Width and number of alert pulses
  always @(posedge clock) begin
    if (!alert_n) begin
      run <= run + 32'h1;
    end else if (run != 32'h0) begin
      alert_width <= run;
      alert_count <= alert_count + 32'h1;
      run <= 32'h0;
    end
  end
  // Third of a bit time (12 clocks, one SCL high phase)
  task automatic half();
    repeat (12) @(posedge clock);
  endtask
  task automatic bit_io(input logic b, output logic seen);
    sda_low <= !b;
    half();
    scl <= 1'b1;
    half();
    seen = sda_line;
    scl <= 1'b0;
    half();
  endtask
  task automatic write_reg(input logic [7:0] idx, input logic [7:0] val,
    output logic ok);
    logic [23:0] frame;
    logic s;
    frame = {`CHG_I2C_ADDR, 1'b0, idx, val};
    ok = 1'b1;
    sda_low <= 1'b1;
    half();
    scl <= 1'b0;
    half();
    for (int i = 23; i >= 0; i--) begin
      bit_io(frame[i], s);
      if (i % 8 == 0) begin
        bit_io(1'b1, s);
        ok = ok & !s;
      end
    end
    sda_low <= 1'b1;
    half();
    scl <= 1'b1;
    half();
    sda_low <= 1'b0;
    half();
  endtask
endmodule // chg_host_model
`default_nettype wire

// >>> tb/chg_pins_tb.sv
`default_nettype none
`include "chg_regs.svh"
module chg_pins_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, reset, avs_read, avs_write, avs_waitrequest, irq;
  logic [7:0] avs_address;
  logic [3:0] avs_byteenable;
  logic dcd_contact_in, primary_det_in, secondary_det_in;
  logic [31:0] avs_writedata, avs_readdata, alert_width, alert_count, q;
  logic charge_enable_n, source_select_in, ship_wake_reset_n, charge_on;
  logic ship_wake_driven, thermistor_window_ok, source_good_in, fault_in;
  logic charge_done_in, scl_in, sda_line, sda_low, sda_oe, host_alert_oe;
  logic charge_state_oe, supply_good_oe, battery_switch_on, ok;
  logic [4:0] input_current_limit_setting;
  int num_errors, num_checks, cyc, n;
  // Pulled-up data line
  assign sda_line = !(sda_oe || sda_low);
  chg_pins #(.ALERT_CYC(20), .RESET_HOLD_CYC(200), .SWITCH_OFF_CYC(50),
    .SHIP_EXIT_CYC(30), .BLINK_HALF_CYC(16), .BC_STEP_CYC(8),
    .DCD_TMO_CYC(40)) dut_u (.clock, .reset, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .charge_enable_n, .source_select_in,
    .ship_wake_reset_n, .ship_wake_driven, .thermistor_window_ok,
    .source_good_in, .fault_in, .charge_done_in, .dcd_contact_in,
    .primary_det_in, .secondary_det_in, .scl_in,
    .sda_in(sda_line), .sda_out(), .sda_oe, .host_alert_oe,
    .charge_state_oe, .supply_good_oe, .battery_switch_on, .charge_on,
    .input_current_limit_setting, .irq);
  chg_host_model host_u (.clock, .sda_line, .alert_n(!host_alert_oe),
    .scl(scl_in), .sda_low, .alert_width, .alert_count);
  // Clock and hang guard
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end
  task automatic wt(input int k);
    repeat (k) @(posedge clock);
  endtask
  task automatic chk(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // Register bus cycle
  task automatic av(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h000000, d};
    do begin
      @(posedge clock);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    chk("waitrequest", avs_waitrequest, 1'b0);
  endtask
  task automatic t_reset();
    chk("switch", battery_switch_on, 1'b1);
    chk("limit", input_current_limit_setting, 5'h05);
    av(1'b0, 8'h14, 8'h00);
    chk("irq_en", q, 32'h0);
    av(1'b0, 8'h3C, 8'h00);
    chk("unmapped", q, 32'h0);
    av(1'b1, 8'h10, 8'h0F);
    wt(2);
    chk("irq", irq, 1'b0);
    $display("test reset done");
  endtask
  task automatic t_charge();
    source_good_in <= 1'b1;
    charge_enable_n <= 1'b0;
    wt(6);
    chk("charge", charge_on, 1'b1);
    chk("stat", charge_state_oe, 1'b1);
    chk("good", supply_good_oe, 1'b1);
    charge_enable_n <= 1'b1;
    wt(6);
    chk("charge", charge_on, 1'b0);
    charge_enable_n <= 1'b0;
    thermistor_window_ok <= 1'b0;
    wt(6);
    chk("charge", charge_on, 1'b0);
    n = 0;
    ok = charge_state_oe;
    repeat (64) begin
      @(posedge clock);
      if (charge_state_oe !== ok) n++;
      ok = charge_state_oe;
    end
    chk("blink", n, 4);
    thermistor_window_ok <= 1'b1;
    charge_done_in <= 1'b1;
    wt(6);
    chk("stat", charge_state_oe, 1'b0);
    charge_done_in <= 1'b0;
    wt(6);
    chk("stat", charge_state_oe, 1'b1);
    charge_enable_n <= 1'b1;
    source_good_in <= 1'b0;
    wt(6);
    chk("good", supply_good_oe, 1'b0);
    $display("test charge done");
  endtask
  task automatic t_limit();
    source_select_in <= 1'b0;
    wt(6);
    chk("limit", input_current_limit_setting, 5'h18);
    av(1'b1, 8'h04, 8'h0C);
    wt(2);
    chk("limit", input_current_limit_setting, 5'h18);
    host_u.write_reg(`CHG_IDX_CTRL, 8'h01, ok);
    chk("ack", ok, 1'b1);
    host_u.write_reg(`CHG_IDX_ILIM, 8'h0C, ok);
    wt(4);
    chk("limit", input_current_limit_setting, 5'h0C);
    av(1'b0, 8'h04, 8'h00);
    chk("limit_reg", q, 32'h0C);
    av(1'b1, 8'h00, 8'h00);
    source_select_in <= 1'b1;
    wt(6);
    chk("limit", input_current_limit_setting, 5'h05);
    $display("test limit done");
  endtask
  task automatic t_alert();
    av(1'b1, 8'h14, 8'h02);
    wt(30);
    av(1'b1, 8'h10, 8'h0F);
    n = alert_count;
    fault_in <= 1'b1;
    wt(4);
    chk("alert", host_alert_oe, 1'b1);
    wt(30);
    chk("width", alert_width, 32'd20);
    chk("pulses", alert_count, n + 1);
    chk("irq", irq, 1'b1);
    av(1'b1, 8'h10, 8'h02);
    wt(2);
    chk("irq", irq, 1'b0);
    av(1'b1, 8'h14, 8'h00);
    fault_in <= 1'b0;
    wt(30);
    fault_in <= 1'b1;
    wt(30);
    chk("irq", irq, 1'b0);
    av(1'b0, 8'h0C, 8'h00);
    chk("irq_stat", q[1], 1'b1);
    fault_in <= 1'b0;
    av(1'b1, 8'h10, 8'h0F);
    $display("test alert done");
  endtask
  task automatic t_wake();
    source_good_in <= 1'b1;
    av(1'b1, 8'h00, 8'h02);
    wt(2);
    chk("switch", battery_switch_on, 1'b0);
    ship_wake_reset_n <= 1'b0;
    wt(10);
    ship_wake_reset_n <= 1'b1;
    wt(40);
    chk("switch", battery_switch_on, 1'b0);
    ship_wake_driven <= 1'b0;
    ship_wake_reset_n <= 1'b0;
    wt(60);
    chk("switch", battery_switch_on, 1'b0);
    ship_wake_driven <= 1'b1;
    wt(20);
    chk("switch", battery_switch_on, 1'b0);
    wt(20);
    chk("switch", battery_switch_on, 1'b1);
    ship_wake_reset_n <= 1'b1;
    source_good_in <= 1'b0;
    wt(4);
    ship_wake_reset_n <= 1'b0;
    wt(190);
    chk("switch", battery_switch_on, 1'b1);
    wt(20);
    chk("switch", battery_switch_on, 1'b0);
    wt(30);
    chk("switch", battery_switch_on, 1'b0);
    wt(40);
    chk("switch", battery_switch_on, 1'b1);
    ship_wake_reset_n <= 1'b1;
    $display("test wake done");
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    {dcd_contact_in, primary_det_in, secondary_det_in} = 3'b000;
    {num_errors, num_checks, cyc} = '0;
    {avs_byteenable, charge_enable_n, source_select_in,
      ship_wake_reset_n} = 7'h7F;
    {ship_wake_driven, thermistor_window_ok} = 2'b11;
    {source_good_in, fault_in, charge_done_in} = 3'b000;
    reset = 1'b1;
    wt(4);
    reset <= 1'b0;
    wt(1);
    t_reset();
    t_charge();
    t_limit();
    t_alert();
    t_wake();
    report_and_stop();
  end
endmodule // chg_pins_tb
`default_nettype wire
